// ===== hw/alog_event_log.sv
/*
 Sticky sixteen-event alarm log with per-event mask, keypad views for
 status, mask editing and the description list, a flow pulse counter and
 an AXI4-Lite register slave.
 Assumes: event inputs and view select come from logic on clk; keys and
 the flow pulse are asynchronous pins; one 10 MHz clock, synchronous reset.
*/
`default_nettype none

module alog_event_log
   import alog_pkg::*;
#(
   parameter int CONFIRM_CYCLES = CONFIRM_CYC,
   parameter int MS_CYCLES = MS_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] event_in,
   input wire logic [1:0] view_sel,
   input wire logic up_key_pin,
   input wire logic down_key_pin,
   input wire logic enter_key_pin,
   input wire logic escape_key_pin,
   input wire logic flow_pulse_pin,
   input wire logic [15:0] dac_a_value,
   input wire logic [15:0] dac_b_value,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic [127:0] disp_line,
   output logic [15:0] log_bits,
   output logic [3:0] cursor_pos,
   output logic cursor_on,
   output logic confirm_on,
   output logic [3:0] list_index
);
   if (CONFIRM_CYCLES < 1 || MS_CYCLES < 1) begin : g_chk
      $error("alog_event_log: cycle counts must be at least one");
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      alog_mode_t mode;
      logic [1:0] view_q;
      logic [15:0] log, mask, edit;
      logic [3:0] cursor, list_idx;
      logic [31:0] timer, ms_div;
      logic [15:0] ms_cnt, intv_cfg;
      logic [31:0] prun, pcount;
      logic [15:0] intv_ms;
      logic aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [127:0] line;
   } alog_state_t;

   alog_state_t q, n;
   logic up_p, down_p, enter_p, esc_p, flow_p;
   logic clr, tick, intv_end, same_view, cfg_wr;
   logic [15:0] cfg_eff, ev_live, mshow;
   logic [7:0] ch;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   alog_key_sync u_up (.clk(clk), .rst(rst), .pin(up_key_pin), .rise(up_p));
   alog_key_sync u_dn (.clk(clk), .rst(rst), .pin(down_key_pin), .rise(down_p));
   alog_key_sync u_en (.clk(clk), .rst(rst), .pin(enter_key_pin), .rise(enter_p));
   alog_key_sync u_es (.clk(clk), .rst(rst), .pin(escape_key_pin), .rise(esc_p));
   alog_key_sync u_fl (.clk(clk), .rst(rst), .pin(flow_pulse_pin), .rise(flow_p));

   function automatic logic [7:0] hex_chr(input logic [3:0] v);
      hex_chr = (v < 4'ha) ? CHR_0 + {4'h0, v} : CHR_A_OFS + {4'h0, v};
   endfunction
   // Unmapped addresses answer SLVERR with zero data
   function automatic logic [32:0] rd_mux(input alog_state_t s,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [15:0] da,
                                          input logic [15:0] db);
      logic [31:0] st;
      st = '0;
      st[ST_MODE_LSB +: 2] = s.mode;
      st[ST_CURSOR_LSB +: 4] = s.cursor;
      st[ST_LIST_LSB +: 4] = s.list_idx;
      st[ST_VIEW_LSB +: 2] = s.view_q;
      case (a)
         OFS_LOG: rd_mux = {1'b1, 16'h0000, s.log};
         OFS_MASK: rd_mux = {1'b1, 16'h0000, s.mask};
         OFS_CTRL: rd_mux = {1'b1, 32'h0000_0000};
         OFS_STATUS: rd_mux = {1'b1, st};
         OFS_PCOUNT: rd_mux = {1'b1, s.pcount};
         OFS_INTV_MS: rd_mux = {1'b1, 16'h0000, s.intv_ms};
         OFS_INTV_CFG: rd_mux = {1'b1, 16'h0000, s.intv_cfg};
         OFS_DAC_A: rd_mux = {1'b1, 16'h0000, da};
         OFS_DAC_B: rd_mux = {1'b1, 16'h0000, db};
         default: rd_mux = {1'b0, 32'h0000_0000};
      endcase
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [32:0] rd;
      rd = '0;
      n = q;
      clr = 1'b0;
      cfg_wr = 1'b0;
      same_view = (view_sel == q.view_q);
      n.view_q = view_sel;
      // Keypad modes; leaving a view drops any pending action
      if (!same_view) begin
         n.mode = ALOG_IDLE;
      end else begin
         case (q.mode)
            ALOG_IDLE: begin
               if (enter_p) begin
                  case (view_sel)
                     VIEW_STATUS: begin
                        n.mode = ALOG_CONFIRM;
                        n.timer = 32'(CONFIRM_CYCLES - 1);
                     end
                     VIEW_MASK: begin
                        n.mode = ALOG_EDIT;
                        n.cursor = 4'h0;
                        n.edit = q.mask;
                     end
                     VIEW_LIST: n.mode = ALOG_SCROLL;
                     default: n.mode = ALOG_IDLE;
                  endcase
               end
            end
            ALOG_CONFIRM: begin
               if (enter_p) begin
                  clr = 1'b1;
                  n.mode = ALOG_IDLE;
               end else if (q.timer == 32'h0) begin
                  n.mode = ALOG_IDLE;
               end else begin
                  n.timer = q.timer - 32'h1;
               end
            end
            ALOG_EDIT: begin
               if (enter_p) begin
                  n.mask = q.edit;
                  n.mode = ALOG_IDLE;
               end else if (esc_p) begin
                  n.mode = ALOG_IDLE;
               end else begin
                  if (down_p) begin
                     n.cursor = q.cursor + 4'h1;
                  end
                  if (up_p) begin
                     n.edit[q.cursor] = ~q.edit[q.cursor];
                  end
               end
            end
            ALOG_SCROLL: begin
               if (enter_p || esc_p) begin
                  n.mode = ALOG_IDLE;
               end else if (down_p) begin
                  n.list_idx = q.list_idx + 4'h1;
               end else if (up_p) begin
                  n.list_idx = q.list_idx - 4'h1;
               end
            end
            default: n.mode = ALOG_IDLE;
         endcase
      end
      // Bus slave: address and data taken in either order
      n.bvalid = q.bvalid && !bready;
      if (awvalid && !q.aw_held) begin
         n.aw_held = 1'b1;
         n.awaddr = awaddr;
      end
      if (wvalid && !q.w_held) begin
         n.w_held = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      if (q.aw_held && q.w_held && !q.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         // Read-only registers take writes silently, unchanged
         case (q.awaddr)
            OFS_MASK: begin
               if (q.wstrb[0]) n.mask[7:0] = q.wdata[7:0];
               if (q.wstrb[1]) n.mask[15:8] = q.wdata[15:8];
            end
            OFS_CTRL: clr = clr | (q.wstrb[0] & q.wdata[CTRL_CLR_BIT]);
            OFS_INTV_CFG: begin
               cfg_wr = 1'b1;
               if (q.wstrb[0]) n.intv_cfg[7:0] = q.wdata[7:0];
               if (q.wstrb[1]) n.intv_cfg[15:8] = q.wdata[15:8];
            end
            OFS_LOG, OFS_STATUS, OFS_PCOUNT, OFS_INTV_MS, OFS_DAC_A, OFS_DAC_B: ;
            default: n.bresp = RESP_SLVERR;
         endcase
      end
      n.rvalid = q.rvalid && !rready;
      if (arvalid && !q.rvalid) begin
         rd = rd_mux(q, araddr, dac_a_value, dac_b_value);
         n.rvalid = 1'b1;
         n.rdata = rd[31:0];
         n.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      end
      // Log: unmasked events set, clear wins
      ev_live = event_in & ~q.mask;
      n.log = clr ? 16'h0000 : (q.log | ev_live);
      // Pulse counting over the configured interval
      cfg_eff = (q.intv_cfg == 16'h0) ? 16'h1 : q.intv_cfg;
      tick = (q.ms_div == 32'(MS_CYCLES - 1));
      intv_end = tick && ((q.ms_cnt + 16'h1) >= cfg_eff);
      n.ms_div = tick ? 32'h0 : q.ms_div + 32'h1;
      if (intv_end) begin
         n.pcount = q.prun + {31'h0, flow_p};
         n.intv_ms = q.ms_cnt + 16'h1;
         n.prun = 32'h0;
         n.ms_cnt = 16'h0;
      end else begin
         n.prun = q.prun + {31'h0, flow_p};
         if (tick) begin
            n.ms_cnt = q.ms_cnt + 16'h1;
         end
      end
      // A new length restarts the interval, so no report mixes two lengths
      if (cfg_wr) begin
         n.ms_div = 32'h0;
         n.ms_cnt = 16'h0;
         n.prun = 32'h0;
      end
      // Display line from the new state, position 0 leftmost
      mshow = (n.mode == ALOG_EDIT) ? n.edit : n.mask;
      for (int i = 0; i < 16; i++) begin
         case (view_sel)
            VIEW_STATUS: ch = n.log[i] ? hex_chr(4'(i)) : CHR_DOT;
            VIEW_MASK: ch = mshow[i] ? CHR_STAR : hex_chr(4'(i));
            VIEW_LIST: ch = (i == 0) ? hex_chr(n.list_idx) : CHR_SPACE;
            default: ch = CHR_SPACE;
         endcase
         n.line[127 - 8 * i -: 8] = ch;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.mask <= MASK_RST;
         q.intv_cfg <= INTV_CFG_RST;
         q.line <= {16{CHR_DOT}};
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign awready = !q.aw_held;
   assign wready = !q.w_held;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = !q.rvalid;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign disp_line = q.line;
   assign log_bits = q.log;
   assign cursor_pos = q.cursor;
   assign cursor_on = (q.mode == ALOG_EDIT);
   assign confirm_on = (q.mode == ALOG_CONFIRM);
   assign list_index = q.list_idx;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [31:0] conf_age;
   always_ff @(posedge clk) begin
      if (rst || q.mode != ALOG_CONFIRM) begin
         conf_age <= 32'h0;
      end else begin
         conf_age <= conf_age + 32'h1;
      end
   end
   mask_blocks_latch_a: assert property (((q.log & ~$past(q.log)) & $past(q.mask)) == 16'h0)
      else $error("masked event latched");
   unmasked_latch_a: assert property (!clr |=> ((q.log & $past(ev_live)) == $past(ev_live)))
      else $error("live event not latched");
   clear_wins_a: assert property (clr |=> q.log == 16'h0)
      else $error("clear did not empty log");
   log_sticky_a: assert property (!clr |=> ((q.log & $past(q.log)) == $past(q.log)))
      else $error("latched bit lost");
   confirm_window_a: assert property (q.mode == ALOG_CONFIRM |->
      conf_age < 32'(CONFIRM_CYCLES))
      else $error("confirm window too long");
   status_ends_a: assert property ((q.view_q == VIEW_STATUS) |->
      (q.line[7:0] == (q.log[15] ? CHR_F : CHR_DOT)
       && q.line[127:120] == (q.log[0] ? CHR_0 : CHR_DOT)))
      else $error("status line end positions wrong");
   mask_star_a: assert property ((q.view_q == VIEW_MASK && q.mode != ALOG_EDIT) |->
      q.line[127:120] == (q.mask[0] ? CHR_STAR : CHR_0))
      else $error("mask view character wrong");
   edit_start_a: assert property ((q.mode == ALOG_IDLE && enter_p && same_view
      && view_sel == VIEW_MASK) |=> (q.mode == ALOG_EDIT && q.cursor == 4'h0
      && q.edit == $past(q.mask)))
      else $error("edit did not start at event 0");
   scroll_step_a: assert property ((q.mode == ALOG_SCROLL && same_view && down_p
      && !enter_p && !esc_p) |=> q.list_idx == $past(q.list_idx) + 4'h1)
      else $error("scroll did not advance");
   scroll_exit_a: assert property ((q.mode == ALOG_SCROLL && (enter_p || esc_p))
      |=> q.mode == ALOG_IDLE)
      else $error("scroll not left");
   diag_stable_a: assert property (!intv_end |=> $stable(q.pcount) && $stable(q.intv_ms))
      else $error("diagnostic changed outside interval end");
   interval_len_a: assert property (intv_end |=> q.intv_ms == $past(cfg_eff))
      else $error("interval length wrong");
   clear_done_c: cover property (q.mode == ALOG_CONFIRM && enter_p ##1 q.log == 16'h0);
   mask_saved_c: cover property (q.mode == ALOG_EDIT && enter_p && q.edit != q.mask);
   scroll_left_c: cover property (q.mode == ALOG_SCROLL && esc_p);
   interval_c: cover property (intv_end && q.prun != 32'h0);
endmodule

`default_nettype wire

// ===== hw/alog_pkg.sv
/*
 Shared constants for the alarm event log with mask: register map, field
 positions, reset values, character codes, view codes and timing counts.
 Assumes a single 10 MHz system clock.
*/
`default_nettype none

package alog_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int CONFIRM_S = 2;
   localparam int CONFIRM_CYC = CONFIRM_S * CLK_HZ;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYC = CLK_HZ / MS_PER_S;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_LOG = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_PCOUNT = 8'h10;
   localparam logic [7:0] OFS_INTV_MS = 8'h14;
   localparam logic [7:0] OFS_INTV_CFG = 8'h18;
   localparam logic [7:0] OFS_DAC_A = 8'h1c;
   localparam logic [7:0] OFS_DAC_B = 8'h20;

   localparam int CTRL_CLR_BIT = 0;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_CURSOR_LSB = 4;
   localparam int ST_LIST_LSB = 8;
   localparam int ST_VIEW_LSB = 12;

   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] INTV_CFG_RST = 16'h0fa0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // Display characters and views
   // ****************************************
   localparam logic [7:0] CHR_DOT = 8'h2e;
   localparam logic [7:0] CHR_STAR = 8'h2a;
   localparam logic [7:0] CHR_SPACE = 8'h20;
   localparam logic [7:0] CHR_0 = 8'h30;
   localparam logic [7:0] CHR_A_OFS = 8'h37;
   localparam logic [7:0] CHR_F = 8'h46;

   localparam logic [1:0] VIEW_STATUS = 2'h0;
   localparam logic [1:0] VIEW_LIST = 2'h1;
   localparam logic [1:0] VIEW_MASK = 2'h2;

   typedef enum logic [1:0] {
      ALOG_IDLE = 2'b00,
      ALOG_CONFIRM = 2'b01,
      ALOG_EDIT = 2'b10,
      ALOG_SCROLL = 2'b11
   } alog_mode_t;
endpackage

`default_nettype wire

// ===== hw/alog_key_sync.sv
/*
 Pin synchroniser: three flip-flops, the level changes once the second and
 third agree, and a one-cycle pulse marks each rising change.
 Assumes an asynchronous pin and the system clock.
*/
`default_nettype none

module alog_key_sync
   import alog_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } alog_sync_t;

   alog_sync_t q_reg;
   alog_sync_t q_next;

   always_comb begin
      q_next = q_reg;
      q_next.s1 = pin;
      q_next.s2 = q_reg.s1;
      q_next.s3 = q_reg.s2;
      q_next.rise = 1'b0;
      // First stage feeds only the second: no logic looks at it
      if (q_reg.s2 == q_reg.s3 && q_reg.s3 != q_reg.level) begin
         q_next.level = q_reg.s3;
         q_next.rise = q_reg.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign rise = q_reg.rise;
endmodule

`default_nettype wire

// ===== sim/alog_keypad_model.sv
/*
 Front-panel user model: presses one key at a time on request.
 Assumes the bench asks for a press only while busy is low.
*/
`default_nettype none

module alog_keypad_model (
   input wire logic clk,
   input wire logic [3:0] press_req,
   output logic up_key_pin,
   output logic down_key_pin,
   output logic enter_key_pin,
   output logic escape_key_pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // Key timing
   // ****************************************
   // Six cycles high, six low: long enough for the synchroniser to see one clean press
   logic [3:0] key_reg = 4'h0;
   int cnt = 0;

   always @(posedge clk) begin
      if (cnt == 0 && press_req != 4'h0) begin
         key_reg <= press_req;
         cnt <= 12;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 7) begin
            key_reg <= 4'h0;
         end
      end
   end

   assign busy = (cnt != 0);
   assign up_key_pin = key_reg[0];
   assign down_key_pin = key_reg[1];
   assign enter_key_pin = key_reg[2];
   assign escape_key_pin = key_reg[3];
endmodule

`default_nettype wire

// ===== sim/tb_alarm_event_log_mask.sv
/*
 Self-checking bench for the alarm event log: keypad, bus and display.
 Assumes short confirm and millisecond counts set by parameter.
*/
`default_nettype none

module tb_alarm_event_log_mask
   import alog_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // Signals
   // ****************************************
   logic clk = 0, rst = 1, flow_pulse_pin = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic cursor_on, confirm_on, up_k, down_k, enter_k, esc_k, kp_busy;
   logic [15:0] event_in = 16'h0000, log_bits;
   logic [1:0] view_sel = 2'h0, bresp, rresp, r;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'h0, cursor_pos, list_index, press_req = 4'h0;
   logic [2:0] fcnt = 3'h0;
   logic [127:0] disp_line;
   int err_count = 0, check_count = 0;

   always #50 clk = ~clk;
   // Period of eight cycles: any 40-cycle interval holds exactly five rises
   always @(posedge clk) begin
      fcnt <= fcnt + 3'h1;
      flow_pulse_pin <= fcnt[2];
   end

   alog_event_log #(.CONFIRM_CYCLES(50), .MS_CYCLES(4)) u_alog_event_log (
      .clk(clk), .rst(rst), .event_in(event_in), .view_sel(view_sel),
      .up_key_pin(up_k), .down_key_pin(down_k), .enter_key_pin(enter_k),
      .escape_key_pin(esc_k), .flow_pulse_pin(flow_pulse_pin),
      .dac_a_value(16'h0c35), .dac_b_value(16'h054e),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .disp_line(disp_line), .log_bits(log_bits),
      .cursor_pos(cursor_pos), .cursor_on(cursor_on), .confirm_on(confirm_on),
      .list_index(list_index));

   alog_keypad_model u_alog_keypad_model (
      .clk(clk), .press_req(press_req), .up_key_pin(up_k), .down_key_pin(down_k),
      .enter_key_pin(enter_k), .escape_key_pin(esc_k), .busy(kp_busy));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [127:0] exp_line(input logic [15:0] b, input logic star);
      logic [127:0] l;
      logic [7:0] c;
      for (int i = 0; i < 16; i++) begin
         c = (i < 10) ? CHR_0 + 8'(i) : CHR_A_OFS + 8'(i);
         if (star) l[127-8*i -: 8] = b[i] ? CHR_STAR : c;
         else l[127-8*i -: 8] = b[i] ? c : CHR_DOT;
      end
      return l;
   endfunction

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic press(input logic [3:0] k);
      @(posedge clk) press_req <= k;
      @(posedge clk) press_req <= 4'h0;
      do @(posedge clk); while (kp_busy);
      #1;
   endtask

   task automatic pulse_ev(input logic [15:0] e);
      @(posedge clk) event_in <= e;
      @(posedge clk) event_in <= 16'h0000;
      tick(2);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk(log_bits, 16'h0000, "log after reset");
      chk(disp_line, exp_line(16'h0000, 1'b0), "dots after reset");
      axi_rd(OFS_MASK, d, r);
      chk(d, 32'h0, "mask reset");
      axi_rd(OFS_INTV_CFG, d, r);
      chk(d, 32'h0fa0, "interval reset");
   endtask

   task automatic t_latch();
      pulse_ev(16'h8006);
      tick(5);
      chk(log_bits, 16'h8006, "sticky bits");
      chk(disp_line, exp_line(16'h8006, 1'b0), "status line");
      axi_rd(OFS_LOG, d, r);
      chk(d, 32'h8006, "log register");
   endtask

   task automatic t_mask();
      axi_wr(OFS_MASK, 32'h0008, r);
      pulse_ev(16'h0018);
      chk(log_bits, 16'h8016, "masked event kept out");
   endtask

   task automatic t_key_clear();
      press(4'h4);
      chk(confirm_on, 1'b1, "confirm open");
      tick(60);
      chk(confirm_on, 1'b0, "confirm expired");
      chk(log_bits, 16'h8016, "no clear after timeout");
      press(4'h4);
      press(4'h4);
      chk(log_bits, 16'h0000, "double enter clears");
   endtask

   task automatic t_bus_clear();
      pulse_ev(16'h0001);
      chk(log_bits, 16'h0001, "bit 0 latched");
      axi_wr(OFS_CTRL, 32'h1, r);
      tick(2);
      chk(log_bits, 16'h0000, "bus clear");
   endtask

   task automatic t_mask_edit();
      @(posedge clk) view_sel <= VIEW_MASK;
      tick(2);
      chk(disp_line, exp_line(16'h0008, 1'b1), "mask view");
      press(4'h4);
      chk({cursor_on, cursor_pos}, 5'h10, "edit at event 0");
      press(4'h1);
      press(4'h2);
      press(4'h2);
      chk(cursor_pos, 4'h2, "cursor moved");
      press(4'h1);
      press(4'h4);
      chk(cursor_on, 1'b0, "edit saved");
      axi_rd(OFS_MASK, d, r);
      chk(d, 32'h000d, "mask toggled");
      chk(disp_line, exp_line(16'h000d, 1'b1), "asterisks");
   endtask

   task automatic t_list();
      @(posedge clk) view_sel <= VIEW_LIST;
      tick(2);
      press(4'h4);
      press(4'h2);
      chk(list_index, 4'h1, "scroll down");
      press(4'h1);
      press(4'h1);
      chk(list_index, 4'hf, "scroll up wraps");
      axi_rd(OFS_STATUS, d, r);
      chk({d[13:12], d[1:0]}, {VIEW_LIST, 2'h3}, "scrolling");
      press(4'h8);
      axi_rd(OFS_STATUS, d, r);
      chk(d[1:0], 2'h0, "escape leaves");
      press(4'h4);
      press(4'h4);
      axi_rd(OFS_STATUS, d, r);
      chk(d[1:0], 2'h0, "enter leaves");
   endtask

   task automatic t_diag();
      axi_wr(OFS_INTV_CFG, 32'd10, r);
      tick(200);
      axi_rd(OFS_PCOUNT, d, r);
      chk(d, 32'd5, "pulse count");
      axi_rd(OFS_INTV_MS, d, r);
      chk(d, 32'd10, "interval ms");
      axi_wr(OFS_PCOUNT, 32'hffff, r);
      chk(r, RESP_OKAY, "read-only write ok");
      axi_wr(OFS_DAC_A, 32'h0, r);
      axi_rd(OFS_DAC_A, d, r);
      chk(d, 32'h0c35, "converter read only");
      axi_rd(OFS_PCOUNT, d, r);
      chk(d, 32'd5, "count unchanged");
   endtask

   task automatic t_unmapped();
      axi_rd(8'h40, d, r);
      chk({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
      axi_wr(8'h40, 32'h1, r);
      chk(r, RESP_SLVERR, "unmapped write");
   endtask

   task automatic t_rereset();
      @(posedge clk) view_sel <= VIEW_STATUS;
      pulse_ev(16'h0100);
      chk(log_bits, 16'h0100, "event latched before reset");
      @(posedge clk) rst <= 1'b1;
      tick(3);
      @(posedge clk) rst <= 1'b0;
      tick(2);
      chk(log_bits, 16'h0000, "reset empties log");
   endtask

   // ****************************************
   // Run control
   // ****************************************
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #3_000_000;
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      t_reset();
      t_latch();
      t_mask();
      t_key_clear();
      t_bus_clear();
      t_mask_edit();
      t_list();
      t_diag();
      t_unmapped();
      t_rereset();
      wrap_up();
   end
endmodule

`default_nettype wire
